/* File: logic/wkt_timer_top.sv */
`timescale 1ns/100ps
// What this block does
// - wake interval code picks 80/160/320/640 ms
// - idle period code zero disables alarm
// - codes 1..11 give 160 ms doubling times
// - codes 12..15 give minute-range doubling times
// - codes 16..20 give hour-range doubling times
// - each idle expiry sets secondary status bit 4
// - reading secondary status clears that bit
// - idle alarm routable to either pin
// - routing bit 7 sends trim fault
// - routing bit 6 sends config fault
// - routing bit 4 sends idle alarm
// - routing bit 3 sends aux high
// - routing bit 2 sends aux low
// - routing bit 1 sends double knock
// - routing bit 0 sends single knock
module wkt_timer_top #(
   parameter logic [23:0] TICK_CYCLES = wkt_pkg::BASE_TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire wkt_pkg::wkt_events_t event_pending,
   output logic irq_pin_one,
   output logic irq_pin_two,
   output logic wake_sample
);

   // word-aligned match of a bus address against a register index
   function automatic logic addr_hit(input logic [11:0] addr, input logic [7:0] idx);
      addr_hit = (addr[11:2] == {2'b00, idx}) && (addr[1:0] == 2'b00);
   endfunction

   // ticks minus one for an idle period code; zero when the code is off
   function automatic logic [20:0] idle_limit(input logic [4:0] code);
      if (code == 5'h00 || code > wkt_pkg::IDLE_PERIOD_MAX_CODE) begin
         idle_limit = 21'h000000;
      end else begin
         idle_limit = (21'h000001 << code) - 21'h000001;
      end
   endfunction

   // base tick from the divider
   logic tick;

   wkt_tick_div #(
      .PERIOD(TICK_CYCLES)
   ) u_tick (
      .core_clk(core_clk),
      .rstn(rstn),
      .tick(tick)
   );

   // registers seen by software
   logic [7:0] timer_control; // wake interval in [7:6], spare [5], idle period [4:0]
   logic [7:0] route_map [2]; // index 0 drives pin one, index 1 pin two
   logic idle_status; // sticky idle-alarm flag of the secondary status
   logic [7:0] next_timer_control;
   logic [7:0] next_route_map [2];
   logic next_idle_status;

   // bus state
   wkt_pkg::wkt_bus_state_t bus_state;
   wkt_pkg::wkt_bus_state_t next_bus_state;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;

   // decoded fields
   logic [1:0] wake_interval;
   logic [4:0] idle_period;
   assign wake_interval = timer_control[wkt_pkg::WAKE_INTERVAL_LSB +: 2];
   assign idle_period = timer_control[wkt_pkg::IDLE_PERIOD_LSB +: 5];

   // the access phase in which this slave completes a transfer
   logic bus_done;
   assign bus_done = (bus_state == wkt_pkg::WKT_BUS_ANSWER) && psel && penable;

   // write strobe for the low byte, where every register lives
   logic wr_ok;
   assign wr_ok = bus_done && pwrite && pstrb[0];

   // setup-phase read mux; the answer is registered so prdata leaves a flop
   logic [7:0] rd_byte;
   logic rd_mapped;
   always_comb begin
      rd_byte = 8'h00;
      rd_mapped = 1'b1;
      if (addr_hit(paddr, wkt_pkg::IDX_WAKE_IDLE_CONTROL)) begin
         rd_byte = timer_control;
      end else if (addr_hit(paddr, wkt_pkg::IDX_PIN_ONE_ROUTING)) begin
         rd_byte = route_map[0];
      end else if (addr_hit(paddr, wkt_pkg::IDX_PIN_TWO_ROUTING)) begin
         rd_byte = route_map[1];
      end else if (addr_hit(paddr, wkt_pkg::IDX_SECONDARY_STATUS)) begin
         rd_byte[wkt_pkg::IDLE_ALARM_BIT] = idle_status;
      end else begin
         rd_mapped = 1'b0; // unmapped: zero data and an error answer
      end
   end

   // bus phases: setup latches the answer, access phase completes it
   always_comb begin
      next_bus_state = bus_state;
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = pslverr;
      case (bus_state)
         wkt_pkg::WKT_BUS_IDLE: begin
            if (psel && !penable) begin
               next_bus_state = wkt_pkg::WKT_BUS_ANSWER;
               next_prdata = {24'h000000, rd_byte};
               next_pslverr = !rd_mapped;
               next_pready = 1'b1;
            end
         end
         wkt_pkg::WKT_BUS_ANSWER: begin
            if (bus_done) begin
               next_bus_state = wkt_pkg::WKT_BUS_IDLE;
               next_pslverr = 1'b0;
            end else begin
               next_pready = 1'b1; // master not yet in access phase
            end
         end
         default: begin
            next_bus_state = wkt_pkg::WKT_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         bus_state <= wkt_pkg::WKT_BUS_IDLE;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         bus_state <= next_bus_state;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   // writable registers; a control write also restarts the idle count
   logic ctl_write;
   assign ctl_write = wr_ok && addr_hit(paddr, wkt_pkg::IDX_WAKE_IDLE_CONTROL);

   always_comb begin
      next_timer_control = timer_control;
      next_route_map[0] = route_map[0];
      next_route_map[1] = route_map[1];
      if (ctl_write) begin
         next_timer_control = pwdata[7:0];
      end
      if (wr_ok && addr_hit(paddr, wkt_pkg::IDX_PIN_ONE_ROUTING)) begin
         next_route_map[0] = pwdata[7:0] & wkt_pkg::ROUTING_WRITABLE;
      end
      if (wr_ok && addr_hit(paddr, wkt_pkg::IDX_PIN_TWO_ROUTING)) begin
         next_route_map[1] = pwdata[7:0] & wkt_pkg::ROUTING_WRITABLE;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         timer_control <= wkt_pkg::CONTROL_RESET;
         route_map[0] <= wkt_pkg::ROUTING_RESET;
         route_map[1] <= wkt_pkg::ROUTING_RESET;
      end else begin
         timer_control <= next_timer_control;
         route_map[0] <= next_route_map[0];
         route_map[1] <= next_route_map[1];
      end
   end

   // timers count base ticks; the wake count uses >= rather than == so a shorter interval
   // written mid-count expires at the next tick instead of wrapping; a control write restarts the idle count
   logic [2:0] wake_cnt;
   logic [20:0] idle_cnt;
   logic [2:0] next_wake_cnt;
   logic [20:0] next_idle_cnt;
   logic next_wake_sample;
   logic idle_on;
   logic idle_expire;
   logic [2:0] wake_lim;

   always_comb begin
      wake_lim = 3'((4'h1 << wake_interval) - 4'h1);
      idle_on = (idle_period != 5'h00) && (idle_period <= wkt_pkg::IDLE_PERIOD_MAX_CODE);
      idle_expire = idle_on && tick && (idle_cnt >= idle_limit(idle_period));
      next_wake_cnt = wake_cnt;
      next_wake_sample = 1'b0;
      next_idle_cnt = idle_cnt;
      if (tick) begin
         if (wake_cnt >= wake_lim) begin
            next_wake_cnt = 3'h0;
            next_wake_sample = 1'b1;
         end else begin
            next_wake_cnt = wake_cnt + 3'h1;
         end
      end
      if (ctl_write || !idle_on || idle_expire) begin
         next_idle_cnt = 21'h000000; // off codes hold the count at zero
      end else if (tick) begin
         next_idle_cnt = idle_cnt + 21'h000001;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         wake_cnt <= 3'h0;
         idle_cnt <= 21'h000000;
         wake_sample <= 1'b0;
      end else begin
         wake_cnt <= next_wake_cnt;
         idle_cnt <= next_idle_cnt;
         wake_sample <= next_wake_sample;
      end
   end

   // status and pins; a read clears only what it returned, so an expiry
   // landing between setup and access is never lost (set wins)
   logic status_rd_clear;
   assign status_rd_clear = bus_done && !pwrite
      && addr_hit(paddr, wkt_pkg::IDX_SECONDARY_STATUS) && prdata[wkt_pkg::IDLE_ALARM_BIT];

   wkt_pkg::wkt_events_t events_now;
   logic [1:0] pin_req;
   logic [1:0] irq_q;

   always_comb begin
      events_now = event_pending;
      events_now.spare = 1'b0;
      events_now.idle_alarm = idle_status;
      next_idle_status = (idle_status && !status_rd_clear) || idle_expire;
   end

   // one request per pin: any routed event that is pending
   for (genvar p = 0; p < 2; p++) begin : g_pin
      assign pin_req[p] = |(route_map[p] & events_now);
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         idle_status <= wkt_pkg::STATUS_RESET[wkt_pkg::IDLE_ALARM_BIT];
         irq_q <= 2'b00;
      end else begin
         idle_status <= next_idle_status;
         irq_q <= pin_req;
      end
   end

   assign irq_pin_one = irq_q[0];
   assign irq_pin_two = irq_q[1];

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   property p_wake_spacing;
      wake_sample |-> $past(tick) && ($past(wake_cnt) >= $past(wake_lim));
   endproperty
   a_wake_spacing: assert property (p_wake_spacing) else $error("wake pulse off its interval");

   property p_idle_off;
      (idle_period == 5'h00) |-> !idle_expire;
   endproperty
   a_idle_off: assert property (p_idle_off) else $error("idle alarm fired while off");

   // any control write restarts the count, so expiry must land on exactly 2**code ticks
   property p_idle_count;
      idle_expire |-> tick && ((idle_cnt + 21'h000001) == (21'h000001 << idle_period));
   endproperty
   a_idle_count: assert property (p_idle_count) else $error("idle alarm at wrong count");

   property p_idle_undefined;
      (idle_period > wkt_pkg::IDLE_PERIOD_MAX_CODE) |-> !idle_expire && idle_cnt == 21'h000000;
   endproperty
   a_idle_undefined: assert property (p_idle_undefined) else $error("undefined code ran");

   property p_status_set;
      idle_expire |=> idle_status;
   endproperty
   a_status_set: assert property (p_status_set) else $error("expiry did not set status");

   property p_status_clear;
      status_rd_clear && !idle_expire |=> !idle_status;
   endproperty
   a_status_clear: assert property (p_status_clear) else $error("status read did not clear");

   // expected request rebuilt from the sources, not from the pin logic itself
   property p_pin_one;
      ##1 irq_pin_one == $past(|(route_map[0] & {event_pending.trim_fault,
         event_pending.config_fault, 1'b0, idle_status, event_pending.aux_high,
         event_pending.aux_low, event_pending.double_knock, event_pending.single_knock}));
   endproperty
   a_pin_one: assert property (p_pin_one) else $error("pin one not following routing");

   property p_pin_two_alarm;
      idle_status && route_map[1][wkt_pkg::IDLE_ALARM_BIT] |=> irq_pin_two;
   endproperty
   a_pin_two_alarm: assert property (p_pin_two_alarm) else $error("idle alarm not on pin two");

   property p_trim_masked;
      !route_map[0][7] && event_pending.trim_fault && !idle_status
         && ((route_map[0] & event_pending & 8'h4F) == 8'h00) |=> !irq_pin_one;
   endproperty
   a_trim_masked: assert property (p_trim_masked) else $error("unrouted trim fault reached pin");

   property p_bus_answer;
      psel && !penable && !pready |=> pready ##1 !pready;
   endproperty
   a_bus_answer: assert property (p_bus_answer) else $error("bus answer timing wrong");

   c_expire: cover property (idle_expire);
   c_read_clear: cover property (status_rd_clear);
   c_pin_one_rise: cover property ($rose(irq_pin_one));
   c_wake: cover property (wake_sample);

endmodule

/* File: logic/wkt_pkg.sv */
// shared constants and types for the wake and idle-alarm timer block
package wkt_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [7:0] IDX_WAKE_IDLE_CONTROL = 8'h39;
   localparam logic [7:0] IDX_PIN_ONE_ROUTING = 8'h3A;
   localparam logic [7:0] IDX_PIN_TWO_ROUTING = 8'h3B;
   localparam logic [7:0] IDX_SECONDARY_STATUS = 8'h3F;

   // field positions
   localparam int WAKE_INTERVAL_LSB = 6;
   localparam int IDLE_PERIOD_LSB = 0;
   localparam int IDLE_ALARM_BIT = 4;

   // reset values
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] ROUTING_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;

   // bit 5 of a routing register is reserved and reads as zero
   localparam logic [7:0] ROUTING_WRITABLE = 8'hDF;

   // highest idle period code with a defined expiry
   localparam logic [4:0] IDLE_PERIOD_MAX_CODE = 5'h14;

   // base tick: 80 ms, the shortest wake interval; idle code n expires after 2**n ticks
   localparam int BASE_TICK_NS = 80_000_000;
   localparam int CLK_PERIOD_NS = 5;
   localparam logic [23:0] BASE_TICK_CYCLES = 24'(BASE_TICK_NS / CLK_PERIOD_NS);

   // event sources, laid out exactly as the bits of a routing register
   typedef struct packed {
      logic trim_fault;
      logic config_fault;
      logic spare;
      logic idle_alarm;
      logic aux_high;
      logic aux_low;
      logic double_knock;
      logic single_knock;
   } wkt_events_t;

   // register bus answer phases
   typedef enum logic {
      WKT_BUS_IDLE,
      WKT_BUS_ANSWER
   } wkt_bus_state_t;

endpackage

/* File: logic/wkt_tick_div.sv */
`timescale 1ns/100ps
// free-running divider: one-cycle tick every period cycles
module wkt_tick_div #(
   parameter logic [23:0] PERIOD = wkt_pkg::BASE_TICK_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   output logic tick
);

   logic [23:0] cnt; // cycles since the last tick
   logic [23:0] next_cnt;
   logic next_tick;

   // wrap at period minus one so the tick spacing is exactly period cycles
   always_comb begin
      if (cnt >= PERIOD - 24'h000001) begin
         next_cnt = 24'h000000;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + 24'h000001;
         next_tick = 1'b0;
      end
   end

   // register stage
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         cnt <= 24'h000000;
         tick <= 1'b0;
      end else begin
         cnt <= next_cnt;
         tick <= next_tick;
      end
   end

endmodule

/* File: verification/wkt_event_model.sv */
`timescale 1ns/100ps
// far-side event sources: the bench's requests become registered level events
module wkt_event_model (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [7:0] ev_req,
   output wkt_pkg::wkt_events_t event_pending
);
   // sources move only on the clock, like a real detector; the spare and the
   // idle-alarm lines stay low because nothing outside the block drives them
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         event_pending <= '0;
      end else begin
         event_pending <= wkt_pkg::wkt_events_t'(ev_req & 8'hCF);
      end
   end
endmodule

/* File: verification/testbench.sv */
`timescale 1ns/100ps
module testbench;
   // short base tick so the long idle codes finish within the run
   localparam logic [23:0] TICK = 24'h000004;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'hF; // full strobes; only byte lane 0 matters
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] ev_req = 8'h00; // requests to the event model
   wkt_pkg::wkt_events_t event_pending;
   logic irq_pin_one;
   logic irq_pin_two;
   logic wake_sample;
   int err_total = 0;
   int tests_run = 0;

   // 200 MHz clock
   always #2.5 core_clk = ~core_clk;

   wkt_timer_top #(.TICK_CYCLES(TICK)) dut (.core_clk(core_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_pending(event_pending),
      .irq_pin_one(irq_pin_one), .irq_pin_two(irq_pin_two), .wake_sample(wake_sample));

   wkt_event_model u_src (.core_clk(core_clk), .rstn(rstn), .ev_req(ev_req),
      .event_pending(event_pending));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask

   // one apb transfer; an edge passes first so no signal is driven twice in one step
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge core_clk);
      // wait for the answer; a slave that never answers is caught by the watchdog
      while (pready !== 1'b1) begin
         @(posedge core_clk);
         n++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // the slave answers in the first access cycle, so no extra wait is expected
      check(32'(n), 32'h00000000);
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      logic e;
      apb(1'b1, idx, d, rd, e);
      check({31'h00000000, e}, 32'h00000000);
   endtask

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] rd;
      logic e;
      apb(1'b0, idx, 8'h00, rd, e);
      check(rd, {24'h000000, exp});
   endtask

   // reset values, read-back, reserved bit, unmapped place
   task automatic t_regs();
      logic [31:0] rd;
      logic e;
      rdc(8'h39, 8'h00);
      rdc(8'h3A, 8'h00);
      rdc(8'h3F, 8'h00);
      wr(8'h3A, 8'hFF);
      rdc(8'h3A, 8'hDF);
      wr(8'h39, 8'hFF);
      rdc(8'h39, 8'hFF);
      // low byte strobe off: the write must leave the control register alone
      pstrb <= 4'hE;
      wr(8'h39, 8'h00);
      pstrb <= 4'hF;
      rdc(8'h39, 8'hFF);
      // status is read only: a write is ignored without error
      wr(8'h3F, 8'hFF);
      rdc(8'h3F, 8'h00);
      apb(1'b0, 8'h40, 8'h00, rd, e);
      check({31'h00000000, e}, 32'h00000001);
      check(rd, 32'h00000000);
      wr(8'h39, 8'h00);
      wr(8'h3A, 8'h00);
      $display("done: registers");
   endtask

   // each routing bit except idle alarm bit 4 and reserved bit 5 passes its own event and nothing else
   task automatic t_route();
      int bits [6] = '{0, 1, 2, 3, 6, 7};
      logic [7:0] m;
      foreach (bits[i]) begin
         m = 8'h01 << bits[i];
         wr(8'h3A, m);
         ev_req <= ~m;
         cyc(4);
         check({31'h00000000, irq_pin_one}, 32'h00000000);
         ev_req <= m;
         cyc(4);
         check({31'h00000000, irq_pin_one}, 32'h00000001);
         check({31'h00000000, irq_pin_two}, 32'h00000000);
      end
      ev_req <= 8'h00;
      wr(8'h3A, 8'h00);
      $display("done: routing");
   endtask

   // interval between wake pulses for every rate code, measured after settling
   task automatic t_wake();
      int n;
      for (int r = 0; r < 4; r++) begin
         wr(8'h39, 8'(r << 6));
         for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
               @(posedge core_clk);
               n++;
            end while (wake_sample !== 1'b1 && n < 200);
         end
         check(32'(n), 32'(TICK) << r);
      end
      wr(8'h39, 8'h00);
      $display("done: wake interval");
   endtask

   // idle expiry times, status set and cleared by a read, both pins, off codes
   task automatic t_idle();
      logic [4:0] codes [5] = '{5'h01, 5'h02, 5'h03, 5'h05, 5'h0C};
      int n;
      int lo;
      int hi;
      wr(8'h3A, 8'h10);
      wr(8'h3B, 8'h10);
      foreach (codes[i]) begin
         // the tick runs free, so the first tick after the write may come at once
         lo = ((1 << codes[i]) - 1) * int'(TICK);
         hi = (1 << codes[i]) * int'(TICK) + 4;
         wr(8'h39, {3'b000, codes[i]});
         n = 0;
         do begin
            @(posedge core_clk);
            n++;
         end while (irq_pin_one !== 1'b1 && n < 20000);
         check({31'h00000000, n >= lo && n <= hi}, 32'h00000001);
         check({31'h00000000, irq_pin_two}, 32'h00000001);
         wr(8'h39, 8'h00);
         rdc(8'h3F, 8'h10);
         rdc(8'h3F, 8'h00);
         cyc(3);
         check({31'h00000000, irq_pin_one}, 32'h00000000);
      end
      // pin one unrouted while pin two still routed
      wr(8'h3A, 8'h00);
      wr(8'h39, 8'h01);
      cyc(20);
      check({31'h00000000, irq_pin_one}, 32'h00000000);
      check({31'h00000000, irq_pin_two}, 32'h00000001);
      wr(8'h39, 8'h00);
      rdc(8'h3F, 8'h10);
      wr(8'h3A, 8'h10);
      wr(8'h39, 8'h00);
      cyc(200);
      rdc(8'h3F, 8'h00);
      wr(8'h39, 8'h15);
      cyc(200);
      check({31'h00000000, irq_pin_one}, 32'h00000000);
      rdc(8'h3F, 8'h00);
      $display("done: idle alarm");
   endtask

   task automatic stop_test();
      $display("comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog: well beyond the roughly 20k cycles the tests need
   initial begin
      #400000;
      err_total++;
      $display("unexpected at %0t: run hung", $time);
      stop_test();
   end

   initial begin
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      t_regs();
      t_route();
      t_wake();
      t_idle();
      stop_test();
   end
endmodule
